// file: inc/tmioc_defines.svh
`ifndef TMIOC_DEFINES_SVH
`define TMIOC_DEFINES_SVH

// ****************************************
// bus geometry
// ****************************************
`define TMIOC_NUM_CH        6
`define TMIOC_ADDR_W        5
`define TMIOC_DATA_W        8

// ****************************************
// register offsets (base + channel number; START is one shared register)
// ****************************************
`define TMIOC_OFS_MODE      5'h00
`define TMIOC_OFS_IOH       5'h08
`define TMIOC_OFS_IOL       5'h10
`define TMIOC_OFS_START     5'h18

// ****************************************
// reset values and fields
// ****************************************
`define TMIOC_MODE_RST      8'hc0
`define TMIOC_MODE_TOP      2'h3
`define TMIOC_IO_RST        8'h00
`define TMIOC_START_RST     6'h00
`define TMIOC_BIT_PAIR_BD   5
`define TMIOC_BIT_PAIR_AC   4
`define TMIOC_BIT_PHASE_SEL 2
`define TMIOC_FLD_B_LSB     4
`define TMIOC_FLD_A_LSB     0
`define TMIOC_FLD_CAPT_BIT  3
`define TMIOC_FLD_LVL_BIT   2
`define TMIOC_FLD_OFF       4'h0
`define TMIOC_CD_CHANS      6'h09

`endif

// file: inc/tmioc_pkg.sv
package tmioc_pkg;

  // ****************************************
  // decoded operating mode
  // ****************************************
  typedef enum logic [3:0] {
    TMIOC_MODE_NORMAL,
    TMIOC_MODE_RESERVED,
    TMIOC_MODE_PWM1,
    TMIOC_MODE_PWM2,
    TMIOC_MODE_PHASE1,
    TMIOC_MODE_PHASE2,
    TMIOC_MODE_PHASE3,
    TMIOC_MODE_PHASE4,
    TMIOC_MODE_UNDEF
  } tmioc_mode_t;

  // ****************************************
  // per-channel control to the datapath
  // ****************************************
  typedef struct packed {
    tmioc_mode_t mode;
    logic        bufferPairAC;
    logic        bufferPairBD;
    logic [3:0]  captureEn;
    logic [3:0]  compareEn;
  } tmioc_chan_ctrl_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] enable;
  } tmioc_pin_t;

endpackage

// file: core/tmioc_mode_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmioc_defines.svh"

module tmioc_mode_reg #(
  parameter bit HAS_CD    = 1'b1,
  parameter bit HAS_PHASE = 1'b0
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                wrEn,
  input  wire logic [7:0]          wrData,
  output logic      [7:0]          value,
  output tmioc_pkg::tmioc_mode_t   mode
);

  logic [5:0] store_reg;
  logic [5:0] store_next;
  logic [5:0] wrMask;

  // ****************************************
  // writable bits; absent features stay zero
  // ****************************************
  always_comb
  begin
    wrMask = 6'h3f;
    if (!HAS_CD)
    begin
      wrMask[`TMIOC_BIT_PAIR_BD] = 1'b0;
      wrMask[`TMIOC_BIT_PAIR_AC] = 1'b0;
    end
    if (!HAS_PHASE)
    begin
      wrMask[`TMIOC_BIT_PHASE_SEL] = 1'b0;
    end
    store_next = store_reg;
    if (wrEn)
    begin
      store_next = wrData[5:0] & wrMask;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      store_reg <= 6'(`TMIOC_MODE_RST);
    else
      store_reg <= store_next;
  end

  // top pair is wired, not stored
  assign value = {`TMIOC_MODE_TOP, store_reg};

  always_comb
  begin
    case (store_reg[3:0])
      4'h0:    mode = tmioc_pkg::TMIOC_MODE_NORMAL;
      4'h1:    mode = tmioc_pkg::TMIOC_MODE_RESERVED;
      4'h2:    mode = tmioc_pkg::TMIOC_MODE_PWM1;
      4'h3:    mode = tmioc_pkg::TMIOC_MODE_PWM2;
      4'h4:    mode = tmioc_pkg::TMIOC_MODE_PHASE1;
      4'h5:    mode = tmioc_pkg::TMIOC_MODE_PHASE2;
      4'h6:    mode = tmioc_pkg::TMIOC_MODE_PHASE3;
      4'h7:    mode = tmioc_pkg::TMIOC_MODE_PHASE4;
      default: mode = tmioc_pkg::TMIOC_MODE_UNDEF;
    endcase
  end

endmodule
`default_nettype wire

// file: core/tmioc_io_field.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmioc_defines.svh"

module tmioc_io_field (
  input  wire logic [3:0] field,
  input  wire logic       usable,
  output logic            capture,
  output logic            compare,
  output logic            initLevel
);

  // a field that is not usable yields no event at all
  always_comb
  begin
    capture   = usable & field[`TMIOC_FLD_CAPT_BIT];
    compare   = usable & ~field[`TMIOC_FLD_CAPT_BIT] & (field != `TMIOC_FLD_OFF);
    initLevel = field[`TMIOC_FLD_LVL_BIT];
  end

endmodule
`default_nettype wire

// file: core/tmioc_top.sv
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "tmioc_defines.svh"

module tmioc_top #(
  parameter int NUM_CH = `TMIOC_NUM_CH
) (
  input  wire logic                                   clk,
  input  wire logic                                   rstn,
  input  wire logic [`TMIOC_ADDR_W-1:0]               busAddr,
  input  wire logic [`TMIOC_DATA_W-1:0]               busWrData,
  input  wire logic                                   busWrite,
  input  wire logic                                   busRead,
  input  wire logic [NUM_CH-1:0]                      counterClear,
  output logic      [`TMIOC_DATA_W-1:0]               busRdData,
  output logic      [NUM_CH-1:0]                      counterStart,
  output tmioc_pkg::tmioc_chan_ctrl_t [NUM_CH-1:0]    chanCtrl,
  output tmioc_pkg::tmioc_pin_t [NUM_CH-1:0]          chanPins
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0]                                rdData_reg;
  logic [7:0]                                rdData_next;
  logic [NUM_CH-1:0]                         start_reg;
  logic [NUM_CH-1:0]                         start_next;
  logic [7:0]                                ioHigh_reg [NUM_CH];
  logic [7:0]                                ioHigh_next [NUM_CH];
  logic [7:0]                                ioLow_reg [NUM_CH];
  logic [7:0]                                ioLow_next [NUM_CH];
  tmioc_pkg::tmioc_chan_ctrl_t [NUM_CH-1:0]  ctrl_reg;
  tmioc_pkg::tmioc_chan_ctrl_t [NUM_CH-1:0]  ctrl_next;
  tmioc_pkg::tmioc_pin_t [NUM_CH-1:0]        pins_reg;
  tmioc_pkg::tmioc_pin_t [NUM_CH-1:0]        pins_next;

  logic [7:0]                                modeVal [NUM_CH];
  tmioc_pkg::tmioc_mode_t                    modeDec [NUM_CH];
  logic [3:0]                                fldCapt [NUM_CH];
  logic [3:0]                                fldComp [NUM_CH];
  logic [3:0]                                fldLevel [NUM_CH];
  logic [NUM_CH-1:0]                         modeWr;

  // channels that own general registers C and D
  localparam logic [5:0] CD_CHANS = `TMIOC_CD_CHANS;

  // ****************************************
  // per-channel mode registers and io fields
  // ****************************************
  genvar ch;
  genvar p;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      localparam bit HAS_CD = CD_CHANS[ch];
      logic [3:0] usable;
      logic [3:0] field [4];

      assign modeWr[ch] = busWrite && (busAddr == `TMIOC_OFS_MODE + 5'(ch));

      tmioc_mode_reg #(
        .HAS_CD    (HAS_CD),
        .HAS_PHASE (!HAS_CD)
      ) u_mode (
        .clk    (clk),
        .rstn   (rstn),
        .wrEn   (modeWr[ch]),
        .wrData (busWrData),
        .value  (modeVal[ch]),
        .mode   (modeDec[ch])
      );

      // high register holds A and B, low register C and D
      assign field[0] = ioHigh_reg[ch][`TMIOC_FLD_A_LSB +: 4];
      assign field[1] = ioHigh_reg[ch][`TMIOC_FLD_B_LSB +: 4];
      assign field[2] = ioLow_reg[ch][`TMIOC_FLD_A_LSB +: 4];
      assign field[3] = ioLow_reg[ch][`TMIOC_FLD_B_LSB +: 4];
      assign usable[1:0] = 2'h3;
      assign usable[2] = HAS_CD && !modeVal[ch][`TMIOC_BIT_PAIR_AC];
      assign usable[3] = HAS_CD && !modeVal[ch][`TMIOC_BIT_PAIR_BD];

      for (p = 0; p < 4; p++)
      begin : g_pin
        tmioc_io_field u_fld (
          .field     (field[p]),
          .usable    (usable[p]),
          .capture   (fldCapt[ch][p]),
          .compare   (fldComp[ch][p]),
          .initLevel (fldLevel[ch][p])
        );
      end
    end
  endgenerate

  // ****************************************
  // register writes and read mux
  // ****************************************
  always_comb
  begin
    start_next  = start_reg;
    rdData_next = 8'h00;
    for (int k = 0; k < NUM_CH; k++)
    begin
      ioHigh_next[k] = ioHigh_reg[k];
      ioLow_next[k]  = ioLow_reg[k];
      if (busWrite && busAddr == `TMIOC_OFS_IOH + 5'(k))
      begin
        ioHigh_next[k] = busWrData;
      end
      if (busWrite && busAddr == `TMIOC_OFS_IOL + 5'(k) && CD_CHANS[k])
      begin
        ioLow_next[k] = busWrData;
      end
      if (busRead && busAddr == `TMIOC_OFS_MODE + 5'(k))
        rdData_next = modeVal[k];
      if (busRead && busAddr == `TMIOC_OFS_IOH + 5'(k))
        rdData_next = ioHigh_reg[k];
      if (busRead && busAddr == `TMIOC_OFS_IOL + 5'(k))
        rdData_next = ioLow_reg[k];
    end
    if (busWrite && busAddr == `TMIOC_OFS_START)
      start_next = busWrData[NUM_CH-1:0];
    if (busRead && busAddr == `TMIOC_OFS_START)
      rdData_next = 8'(start_reg);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdData_reg <= 8'h00;
      start_reg  <= `TMIOC_START_RST;
      for (int k = 0; k < NUM_CH; k++)
      begin
        ioHigh_reg[k] <= `TMIOC_IO_RST;
        ioLow_reg[k]  <= `TMIOC_IO_RST;
      end
    end
    else
    begin
      rdData_reg <= rdData_next;
      start_reg  <= start_next;
      for (int k = 0; k < NUM_CH; k++)
      begin
        ioHigh_reg[k] <= ioHigh_next[k];
        ioLow_reg[k]  <= ioLow_next[k];
      end
    end
  end

  // ****************************************
  // channel control and pin levels
  // ****************************************
  always_comb
  begin
    for (int k = 0; k < NUM_CH; k++)
    begin
      ctrl_next[k].mode         = modeDec[k];
      ctrl_next[k].bufferPairAC = modeVal[k][`TMIOC_BIT_PAIR_AC];
      ctrl_next[k].bufferPairBD = modeVal[k][`TMIOC_BIT_PAIR_BD];
      ctrl_next[k].captureEn    = fldCapt[k];
      ctrl_next[k].compareEn    = fldComp[k];
      pins_next[k].enable       = fldComp[k];
      pins_next[k].level        = pins_reg[k].level;
      for (int q = 0; q < 4; q++)
      begin
        if (!fldComp[k][q])
          pins_next[k].level[q] = 1'b0;
        else if (!start_reg[k])
          pins_next[k].level[q] = fldLevel[k][q];
        else if (counterClear[k] && modeDec[k] == tmioc_pkg::TMIOC_MODE_PWM2)
          pins_next[k].level[q] = fldLevel[k][q];
      end
    end
  end

  // counting itself lives elsewhere; pins only hold between events
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_reg <= '0;
      pins_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      pins_reg <= pins_next;
    end
  end

  assign busRdData    = rdData_reg;
  assign counterStart = start_reg;
  assign chanCtrl     = ctrl_reg;
  assign chanPins     = pins_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_top_ones;
    busRead && busAddr == `TMIOC_OFS_MODE + 5'h2 |=> busRdData[7:6] == 2'h3;
  endproperty
  a_top_ones: assert property (p_top_ones) else $error("mode top bits not held at one");

  property p_chan_indep;
    modeWr[0] |=> $stable(modeVal[1]) && $stable(modeVal[3]);
  endproperty
  a_chan_indep: assert property (p_chan_indep) else $error("mode write leaked to another channel");

  property p_no_cd_bits;
    modeWr[4] && busWrData[5:4] == 2'h3 |=> modeVal[4][5:4] == 2'h0;
  endproperty
  a_no_cd_bits: assert property (p_no_cd_bits) else $error("buffer bits writable without C and D");

  property p_no_phase;
    modeWr[3] && busWrData[2] |=> !modeVal[3][2] ##1 chanCtrl[3].mode != tmioc_pkg::TMIOC_MODE_PHASE1;
  endproperty
  a_no_phase: assert property (p_no_phase) else $error("phase counting selectable on channel 3");

  property p_decode_pwm2;
    modeWr[1] && busWrData[3:0] == 4'h3 |=> ##1 chanCtrl[1].mode == tmioc_pkg::TMIOC_MODE_PWM2;
  endproperty
  a_decode_pwm2: assert property (p_decode_pwm2) else $error("mode field not decoded to PWM2");

  property p_buffer_pair;
    modeWr[0] |=> ##1 chanCtrl[0].bufferPairBD == $past(busWrData[5], 2)
                 && chanCtrl[0].bufferPairAC == $past(busWrData[4], 2);
  endproperty
  a_buffer_pair: assert property (p_buffer_pair) else $error("buffer pairing not reflected");

  property p_buffer_mute;
    modeVal[0][`TMIOC_BIT_PAIR_AC] |=> !chanCtrl[0].captureEn[2] && !chanCtrl[0].compareEn[2]
                                   && !chanPins[0].enable[2];
  endproperty
  a_buffer_mute: assert property (p_buffer_mute) else $error("buffered C still active");

  property p_d_capture;
    modeVal[0][`TMIOC_BIT_PAIR_BD] && ioLow_reg[0][7] |=> !chanCtrl[0].captureEn[3];
  endproperty
  a_d_capture: assert property (p_d_capture) else $error("D capture with B/D paired");

  property p_field_split;
    busWrite && busAddr == `TMIOC_OFS_IOH + 5'h2 && busWrData == 8'h84 |=> ##1
      chanCtrl[2].captureEn[1:0] == 2'h2 && chanCtrl[2].compareEn[1:0] == 2'h1;
  endproperty
  a_field_split: assert property (p_field_split) else $error("io field bit split wrong");

  property p_init_level;
    !start_reg[2] && fldComp[2][0] |=> chanPins[2].level[0] == $past(fldLevel[2][0]);
  endproperty
  a_init_level: assert property (p_init_level) else $error("initial level not driven");

  property p_pwm2_clear;
    start_reg[1] && counterClear[1] && fldComp[1][0]
      && modeDec[1] == tmioc_pkg::TMIOC_MODE_PWM2 |=> chanPins[1].level[0] == $past(fldLevel[1][0]);
  endproperty
  a_pwm2_clear: assert property (p_pwm2_clear) else $error("PWM2 clear level missed");

  property p_read_low;
    busRead && busAddr == `TMIOC_OFS_IOL + 5'h3 |=> busRdData == $past(ioLow_reg[3]) ##1
      ($past(busRead) || busRdData == 8'h00);
  endproperty
  a_read_low: assert property (p_read_low) else $error("low io read data wrong");

  // single-register channels have no low register behind the address
  property p_single_low;
    busRead && busAddr == `TMIOC_OFS_IOL + 5'h2 |=> busRdData == 8'h00;
  endproperty
  a_single_low: assert property (p_single_low) else $error("absent low io reads nonzero");

  // read data must not linger, software may poll back to back
  property p_read_idle;
    !busRead |=> busRdData == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside its cycle");

  property p_start_write;
    busWrite && busAddr == `TMIOC_OFS_START |=> counterStart == $past(busWrData[NUM_CH-1:0]);
  endproperty
  a_start_write: assert property (p_start_write) else $error("start bits not written");

  c_pwm2_clear: cover property (p_pwm2_clear);
  c_buffer_c: cover property (modeVal[0][`TMIOC_BIT_PAIR_AC] ##1 ioLow_reg[0] != 8'h00);
  c_phase_ch1: cover property (chanCtrl[1].mode == tmioc_pkg::TMIOC_MODE_PHASE4);
  c_read_low: cover property (busRead && busAddr == `TMIOC_OFS_IOL + 5'h3);

endmodule
`default_nettype wire

// file: tb/tmioc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmioc_defines.svh"

module tmioc_top_tb;

  logic                                clk;
  logic                                rstn;
  logic [`TMIOC_ADDR_W-1:0]            busAddr;
  logic [`TMIOC_DATA_W-1:0]            busWrData;
  logic                                busWrite;
  logic                                busRead;
  logic [5:0]                          counterClear;
  logic [`TMIOC_DATA_W-1:0]            busRdData;
  logic [5:0]                          counterStart;
  tmioc_pkg::tmioc_chan_ctrl_t [5:0]   chanCtrl;
  tmioc_pkg::tmioc_pin_t [5:0]         chanPins;
  int                                  n_fail;
  int                                  checks;
  int                                  ch;
  logic [7:0]                          expMode;

  tmioc_top #(
    .NUM_CH(6)
  ) uut (
    .clk          (clk),
    .rstn         (rstn),
    .busAddr      (busAddr),
    .busWrData    (busWrData),
    .busWrite     (busWrite),
    .busRead      (busRead),
    .counterClear (counterClear),
    .busRdData    (busRdData),
    .counterStart (counterStart),
    .chanCtrl     (chanCtrl),
    .chanPins     (chanPins)
  );

  always #50 clk = ~clk;

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // strobe raised after one edge, lowered after the next, so calls never collide
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    busAddr   <= a;
    busWrData <= d;
    busWrite  <= 1'b1;
    @(posedge clk);
    busWrite  <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk);
    busRead <= 1'b0;
    #1;
    chk("busRdData", {8'h00, exp}, {8'h00, busRdData});
    @(posedge clk);
    #1;
    chk("busRdData idle", 16'h0000, {8'h00, busRdData});
  endtask

  // control outputs follow a register write two edges later
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    busAddr = 5'h00;
    busWrData = 8'h00;
    busWrite = 1'b0;
    busRead = 1'b0;
    counterClear = 6'h00;
    n_fail = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("chanCtrl0 reset", 16'h0000, 16'(chanCtrl[0]));
    for (ch = 0; ch < 6; ch++)
    begin
      rd(`TMIOC_OFS_MODE + ch[4:0], 8'hc0);
      rd(`TMIOC_OFS_IOH + ch[4:0], 8'h00);
    end
    rd(`TMIOC_OFS_IOL + 5'h00, 8'h00);
    rd(`TMIOC_OFS_IOL + 5'h03, 8'h00);
    $display("test reset values done");

    // all ones: top bits fixed, reserved bits per channel kind dropped
    for (ch = 0; ch < 6; ch++)
      wr(`TMIOC_OFS_MODE + ch[4:0], 8'hff);
    for (ch = 0; ch < 6; ch++)
    begin
      expMode = (ch == 0 || ch == 3) ? 8'hfb : 8'hcf;
      rd(`TMIOC_OFS_MODE + ch[4:0], expMode);
    end
    wr(`TMIOC_OFS_MODE + 5'h00, 8'h02);
    rd(`TMIOC_OFS_MODE + 5'h01, 8'hcf);
    rd(`TMIOC_OFS_MODE + 5'h00, 8'hc2);
    $display("test mode register bits done");

    for (ch = 0; ch < 9; ch++)
    begin
      wr(`TMIOC_OFS_MODE + 5'h01, ch[7:0]);
      settle();
      chk("mode ch1", (ch < 8) ? ch[15:0] : 16'(tmioc_pkg::TMIOC_MODE_UNDEF),
          16'(chanCtrl[1].mode));
    end
    wr(`TMIOC_OFS_MODE + 5'h03, 8'h06);
    settle();
    chk("mode ch3", 16'(tmioc_pkg::TMIOC_MODE_PWM1), 16'(chanCtrl[3].mode));
    $display("test mode decode done");

    // C asks for compare, A, B, D for capture; paired buffers must stay silent
    wr(`TMIOC_OFS_MODE + 5'h00, 8'h30);
    wr(`TMIOC_OFS_IOH + 5'h00, 8'hcc);
    wr(`TMIOC_OFS_IOL + 5'h00, 8'hc4);
    settle();
    chk("pairAC ch0", 16'h0001, 16'(chanCtrl[0].bufferPairAC));
    chk("pairBD ch0", 16'h0001, 16'(chanCtrl[0].bufferPairBD));
    chk("captureEn ch0", 16'h0003, 16'(chanCtrl[0].captureEn));
    chk("compareEn ch0", 16'h0000, 16'(chanCtrl[0].compareEn));
    chk("pin enable ch0", 16'h0000, 16'(chanPins[0].enable));
    wr(`TMIOC_OFS_MODE + 5'h00, 8'h00);
    settle();
    chk("captureEn ch0 unpaired", 16'h000b, 16'(chanCtrl[0].captureEn));
    chk("compareEn ch0 unpaired", 16'h0004, 16'(chanCtrl[0].compareEn));
    chk("pin enable ch0 unpaired", 16'h0004, 16'(chanPins[0].enable));
    rd(`TMIOC_OFS_IOL + 5'h00, 8'hc4);
    $display("test buffer pairing done");

    wr(`TMIOC_OFS_IOH + 5'h02, 8'h84);
    rd(`TMIOC_OFS_IOH + 5'h02, 8'h84);
    chk("captureEn ch2", 16'h0002, 16'(chanCtrl[2].captureEn));
    chk("compareEn ch2", 16'h0001, 16'(chanCtrl[2].compareEn));
    chk("pin enable ch2", 16'h0001, 16'(chanPins[2].enable));
    chk("pin level ch2", 16'h0001, 16'(chanPins[2].level[0]));
    wr(`TMIOC_OFS_IOL + 5'h02, 8'hff);
    rd(`TMIOC_OFS_IOL + 5'h02, 8'h00);
    wr(5'h1f, 8'hff);
    rd(5'h1f, 8'h00);
    $display("test io fields done");

    // level is held while counting; only a PWM2 clear reloads it
    wr(`TMIOC_OFS_MODE + 5'h01, 8'h03);
    wr(`TMIOC_OFS_IOH + 5'h01, 8'h04);
    settle();
    chk("pin level ch1 stopped", 16'h0001, 16'(chanPins[1].level[0]));
    wr(`TMIOC_OFS_START, 8'h02);
    #1;
    chk("counterStart", 16'h0002, 16'(counterStart));
    // compare stays on with a low level, so only a clear may move the pin
    wr(`TMIOC_OFS_IOH + 5'h01, 8'h01);
    settle();
    chk("pin level ch1 running", 16'h0001, 16'(chanPins[1].level[0]));
    @(posedge clk);
    counterClear <= 6'h02;
    @(posedge clk);
    counterClear <= 6'h00;
    settle();
    chk("pin level ch1 cleared", 16'h0000, 16'(chanPins[1].level[0]));
    $display("test start and clear done");
    end_of_test();
  end

  // a full run needs roughly 175 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

endmodule
`default_nettype wire
